// ### rtl/clm_pkg.sv
// shared constants for the card logical channel manager
package clm_pkg;

  // channel numbering: basic channel plus three extra
  localparam int         NUM_CH       = 4;
  localparam int         CH_W         = 2;
  localparam logic [3:0] OPEN_RESET   = 4'h1;
  localparam logic [3:0] CH_ALL_OPEN  = 4'hF;
  localparam logic [1:0] CH_BASIC     = 2'h0;

  // instruction bytes
  localparam logic [7:0] INS_MANAGE   = 8'h70;
  localparam logic [7:0] INS_STATUS   = 8'hF2;
  localparam logic [7:0] INS_SELECT   = 8'hA4;
  localparam logic [7:0] INS_RD_REC   = 8'hB2;
  localparam logic [7:0] INS_RD_BIN   = 8'hB0;

  // parameter byte codes
  localparam logic [7:0] P1_OPEN      = 8'h00;
  localparam logic [7:0] P1_CLOSE     = 8'h80;
  localparam logic [7:0] P1_SEL_FID   = 8'h00;
  localparam logic [7:0] P1_SEL_AID   = 8'h04;

  // file identifiers
  localparam logic [15:0] FID_ROOT    = 16'h3F00;
  localparam logic [15:0] FID_APP_ALS = 16'h7FFF;
  localparam logic [7:0]  FID_DIR_HI1 = 8'h7F;
  localparam logic [7:0]  FID_DIR_HI2 = 8'h5F;

  // status words
  localparam logic [7:0] SW1_OK       = 8'h90;
  localparam logic [7:0] SW2_OK       = 8'h00;
  localparam logic [7:0] SW1_NOT_ALW  = 8'h69;
  localparam logic [7:0] SW2_NO_LEAF  = 8'h86;
  localparam logic [7:0] SW1_WRONG_P  = 8'h6A;
  localparam logic [7:0] SW2_NO_FILE  = 8'h82;
  localparam logic [7:0] SW2_FULL     = 8'h81;
  localparam logic [7:0] SW2_BAD_P12  = 8'h86;
  localparam logic [7:0] SW1_CLA      = 8'h68;
  localparam logic [7:0] SW2_CH_BAD   = 8'h81;
  localparam logic [7:0] SW1_BAD_INS  = 8'h6D;
  localparam logic [7:0] SW2_BAD_INS  = 8'h00;

  // third software function byte of the reset answer
  localparam int         SF3_CARD_BIT = 4;
  localparam int         SF3_HOST_BIT = 3;
  localparam int         SF3_MAX_LSB  = 0;
  localparam logic [7:0] SF3_NONE     = 8'h00;
  localparam logic [2:0] SF3_MAX_CODE = 3'(NUM_CH - 1);

  // command sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_RESP = 2'b10
  } clm_state_t;

endpackage

// ### rtl/clm_free_finder.sv
// lowest free extra channel number finder
`timescale 1ns/100ps
module clm_free_finder
  import clm_pkg::*;
(
  // channel open flags
  input  wire logic [NUM_CH-1:0] open_flags,
  // result
  output logic                   found,
  output logic [CH_W-1:0]        chan_num
);

  // scan from channel 3 downward so the lowest free one wins; channel 0 is never a candidate
  always_comb begin
    found    = 1'b0;
    chan_num = CH_BASIC;
    for (int i = NUM_CH - 1; i >= 1; i--) begin
      if (!open_flags[i]) begin
        found    = 1'b1;
        chan_num = CH_W'(i);
      end
    end
  end

endmodule

// ### rtl/clm_channel_mgr.sv
// logical channel manager of the card command interpreter
//
// Operation
// - at most three extra channels beside basic channel 0, numbers 0 to 3
// - channel 0 always open; closing it errors, its status still succeeds
// - reset answer advertises channel support, assignment method and channel count
// - without support the capability byte shows no channel support
// - without support every open errors, status on channels 1 to 3 errors
// - advertised total channel count lies between 2 and 4
// - card assigns channel numbers and says so in the reset answer
// - one command at a time; nothing accepted until its response is sent
// - successful open picks a free channel, marks it open, returns its number
// - extra channels stay open until closed or reset; reset closes them all
// - closing an open extra channel gives 90 00; later status there errors
// - status on an open channel gives 90 00, on a closed channel errors
// - with every extra channel open, further opens error and assign nothing
// - open issued on an open extra channel assigns a further free channel
// - open from basic channel starts the new channel at the root directory
// - a new channel has no current leaf file; record reads give 69 86
// - open from basic leaves no active application; alias 7FFF gives 6A 82
`timescale 1ns/100ps
module clm_channel_mgr
  import clm_pkg::*;
#(
  parameter bit CHAN_EN = 1'b1
)(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  // command from the terminal side
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic [1:0]  cmd_chan,
  input  wire logic [7:0]  cmd_ins,
  input  wire logic [7:0]  cmd_p1,
  input  wire logic [7:0]  cmd_p2,
  input  wire logic [15:0] cmd_fid,
  // response
  output logic             rsp_valid,
  output logic [7:0]       rsp_sw1,
  output logic [7:0]       rsp_sw2,
  output logic [15:0]      rsp_data,
  // reset answer capability byte
  output logic             atr_sf3_present,
  output logic [7:0]       atr_sf3
);

  clm_state_t       state_reg;
  logic             ready_reg;
  logic             rsp_valid_reg;
  logic [7:0]       sw1_reg;
  logic [7:0]       sw2_reg;
  logic [15:0]      data_reg;
  logic             sf3_present_reg;
  logic [7:0]       sf3_reg;
  logic [1:0]       chan_reg;
  logic [7:0]       ins_reg;
  logic [7:0]       p1_reg;
  logic [7:0]       p2_reg;
  logic [15:0]      fid_reg;
  logic [NUM_CH-1:0] open_reg;
  logic [NUM_CH-1:0] leaf_reg;
  logic [NUM_CH-1:0] app_reg;
  logic [15:0]      dir_reg [NUM_CH];
  logic [15:0]      app_fid_reg [NUM_CH];
  logic             free_found;
  logic [CH_W-1:0]  free_chan;
  logic             exec;
  logic             accept;

  // decoded actions of the command under execution
  logic             act_open;
  logic             act_close;
  logic             act_dir;
  logic             act_leaf;
  logic             act_app;
  logic [1:0]       close_chan;
  logic [7:0]       sw1_next;
  logic [7:0]       sw2_next;
  logic [15:0]      data_next;

  // a channel is usable only when open; channel 0 never closes
  function automatic logic is_open(input logic [NUM_CH-1:0] flags,
                                   input logic [1:0] ch);
    return flags[ch];
  endfunction

  // identifiers with a directory high byte select a directory
  function automatic logic is_dir_fid(input logic [15:0] fid);
    return (fid[15:8] == FID_DIR_HI1) || (fid[15:8] == FID_DIR_HI2);
  endfunction

  assign exec   = (state_reg == ST_EXEC);
  assign accept = cmd_valid && ready_reg;

  clm_free_finder u_free (
    .open_flags (open_reg),
    .found      (free_found),
    .chan_num   (free_chan)
  );

  // serial sequencer: take, execute, answer, then accept again
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
      ready_reg <= 1'b1;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (accept) begin
            state_reg <= ST_EXEC;
            ready_reg <= 1'b0;
          end
        end
        ST_EXEC: begin
          state_reg <= ST_RESP;
        end
        ST_RESP: begin
          state_reg <= ST_IDLE;
          ready_reg <= 1'b1;
        end
        default: begin
          state_reg <= ST_IDLE;
          ready_reg <= 1'b1;
        end
      endcase
    end
  end

  // command capture, held while executing
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      chan_reg <= CH_BASIC;
      ins_reg  <= 8'h00;
      p1_reg   <= 8'h00;
      p2_reg   <= 8'h00;
      fid_reg  <= 16'h0000;
    end else if (accept) begin
      chan_reg <= cmd_chan;
      ins_reg  <= cmd_ins;
      p1_reg   <= cmd_p1;
      p2_reg   <= cmd_p2;
      fid_reg  <= cmd_fid;
    end
  end

  // command decode; a closed channel refuses everything first
  always_comb begin
    act_open   = 1'b0;
    act_close  = 1'b0;
    act_dir    = 1'b0;
    act_leaf   = 1'b0;
    act_app    = 1'b0;
    close_chan = p2_reg[1:0];
    sw1_next   = SW1_OK;
    sw2_next   = SW2_OK;
    data_next  = 16'h0000;
    if (!is_open(open_reg, chan_reg)) begin
      sw1_next = SW1_CLA;
      sw2_next = SW2_CH_BAD;
    end else if (ins_reg == INS_MANAGE) begin
      if (p1_reg == P1_OPEN) begin
        if (!CHAN_EN) begin
          sw1_next = SW1_CLA;
          sw2_next = SW2_CH_BAD;
        end else if (!free_found) begin
          sw1_next = SW1_WRONG_P;
          sw2_next = SW2_FULL;
        end else begin
          act_open  = 1'b1;
          data_next = {14'h0000, free_chan};
        end
      end else if (p1_reg == P1_CLOSE) begin
        if (p2_reg[7:2] != 6'h00 || close_chan == CH_BASIC) begin
          sw1_next = SW1_WRONG_P;
          sw2_next = SW2_BAD_P12;
        end else if (!is_open(open_reg, close_chan)) begin
          sw1_next = SW1_CLA;
          sw2_next = SW2_CH_BAD;
        end else begin
          act_close = 1'b1;
        end
      end else begin
        sw1_next = SW1_WRONG_P;
        sw2_next = SW2_BAD_P12;
      end
    end else if (ins_reg == INS_STATUS) begin
      data_next = dir_reg[chan_reg];
    end else if (ins_reg == INS_SELECT) begin
      if (p1_reg == P1_SEL_AID) begin
        act_app   = 1'b1;
        data_next = fid_reg;
      end else if (p1_reg != P1_SEL_FID) begin
        sw1_next = SW1_WRONG_P;
        sw2_next = SW2_BAD_P12;
      end else if (fid_reg == FID_APP_ALS) begin
        if (app_reg[chan_reg]) begin
          act_dir   = 1'b1;
          data_next = app_fid_reg[chan_reg];
        end else begin
          sw1_next = SW1_WRONG_P;
          sw2_next = SW2_NO_FILE;
        end
      end else if (fid_reg == FID_ROOT || is_dir_fid(fid_reg)) begin
        act_dir   = 1'b1;
        data_next = fid_reg;
      end else begin
        act_leaf  = 1'b1;
        data_next = fid_reg;
      end
    end else if (ins_reg == INS_RD_REC || ins_reg == INS_RD_BIN) begin
      if (!leaf_reg[chan_reg]) begin
        sw1_next = SW1_NOT_ALW;
        sw2_next = SW2_NO_LEAF;
      end
    end else begin
      sw1_next = SW1_BAD_INS;
      sw2_next = SW2_BAD_INS;
    end
  end

  // response registers; one-cycle valid after execution
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_valid_reg <= 1'b0;
      sw1_reg       <= 8'h00;
      sw2_reg       <= 8'h00;
      data_reg      <= 16'h0000;
    end else begin
      rsp_valid_reg <= exec;
      if (exec) begin
        sw1_reg  <= sw1_next;
        sw2_reg  <= sw2_next;
        data_reg <= data_next;
      end
    end
  end

  // open flags; reset leaves only the basic channel open
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      open_reg <= OPEN_RESET;
    end else if (exec) begin
      if (act_open) begin
        open_reg[free_chan] <= 1'b1;
      end else if (act_close) begin
        open_reg[close_chan] <= 1'b0;
      end
      open_reg[0] <= 1'b1;
    end
  end

  // per-channel selection context, kept apart per channel
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      leaf_reg <= 4'h0;
      app_reg  <= 4'h0;
      for (int i = 0; i < NUM_CH; i++) begin
        dir_reg[i]     <= FID_ROOT;
        app_fid_reg[i] <= 16'h0000;
      end
    end else if (exec) begin
      if (act_open) begin
        // new channel never has a leaf file selected
        leaf_reg[free_chan] <= 1'b0;
        if (chan_reg == CH_BASIC) begin
          dir_reg[free_chan] <= FID_ROOT;
          app_reg[free_chan] <= 1'b0;
        end else begin
          // opening from an extra channel inherits its directory and application, not its leaf file
          dir_reg[free_chan]     <= dir_reg[chan_reg];
          app_reg[free_chan]     <= app_reg[chan_reg];
          app_fid_reg[free_chan] <= app_fid_reg[chan_reg];
        end
      end else if (act_close) begin
        // clear stale context so a reopen starts clean
        leaf_reg[close_chan] <= 1'b0;
        app_reg[close_chan]  <= 1'b0;
        dir_reg[close_chan]  <= FID_ROOT;
      end else if (act_app) begin
        app_reg[chan_reg]     <= 1'b1;
        app_fid_reg[chan_reg] <= fid_reg;
        dir_reg[chan_reg]     <= fid_reg;
        leaf_reg[chan_reg]    <= 1'b0;
      end else if (act_dir) begin
        dir_reg[chan_reg]  <= (fid_reg == FID_APP_ALS) ? app_fid_reg[chan_reg] : fid_reg;
        leaf_reg[chan_reg] <= 1'b0;
      end else if (act_leaf) begin
        leaf_reg[chan_reg] <= 1'b1;
      end
    end
  end

  // capability byte is set up after reset release; it never changes
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sf3_present_reg <= 1'b0;
      sf3_reg         <= SF3_NONE;
    end else if (CHAN_EN) begin
      sf3_present_reg <= 1'b1;
      sf3_reg         <= SF3_NONE;
      sf3_reg[SF3_CARD_BIT] <= 1'b1;
      sf3_reg[SF3_MAX_LSB +: 3] <= SF3_MAX_CODE;
    end else begin
      sf3_present_reg <= 1'b1;
      sf3_reg         <= SF3_NONE;
    end
  end

  assign cmd_ready       = ready_reg;
  assign rsp_valid       = rsp_valid_reg;
  assign rsp_sw1         = sw1_reg;
  assign rsp_sw2         = sw2_reg;
  assign rsp_data        = data_reg;
  assign atr_sf3_present = sf3_present_reg;
  assign atr_sf3         = sf3_reg;

  // protocol and context checks; the open check looks back one cycle, to the execute cycle
  chk_basic_always_open: assert property (
    @(posedge sys_clk) disable iff (!arst_n) open_reg[0])
    else $error("basic channel seen closed");
  chk_serial_busy: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    accept |=> !cmd_ready ##1 (!cmd_ready && rsp_valid) ##1 cmd_ready)
    else $error("command overlap or late response");
  chk_close_basic: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    (exec && ins_reg == INS_MANAGE && p1_reg == P1_CLOSE && p2_reg == 8'h00)
    |=> (rsp_sw1 != SW1_OK) && open_reg[0])
    else $error("basic channel close accepted");
  chk_status_closed: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    (exec && ins_reg == INS_STATUS && !open_reg[chan_reg]) |=> rsp_sw1 != SW1_OK)
    else $error("status on closed channel succeeded");
  chk_status_open: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    (exec && ins_reg == INS_STATUS && open_reg[chan_reg])
    |=> rsp_sw1 == SW1_OK && rsp_sw2 == SW2_OK && rsp_data == $past(dir_reg[chan_reg]))
    else $error("status on open channel wrong");
  chk_open_assign: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    (rsp_valid && $past(act_open))
    |-> rsp_sw1 == SW1_OK && open_reg[rsp_data[1:0]] && rsp_data[1:0] != CH_BASIC)
    else $error("open did not assign a channel");
  chk_open_full: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    (exec && ins_reg == INS_MANAGE && p1_reg == P1_OPEN && open_reg == CH_ALL_OPEN)
    |=> rsp_sw1 != SW1_OK && open_reg == CH_ALL_OPEN)
    else $error("open accepted with no free channel");
  chk_new_root: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    (exec && act_open && chan_reg == CH_BASIC)
    |=> dir_reg[rsp_data[1:0]] == FID_ROOT && !leaf_reg[rsp_data[1:0]] && !app_reg[rsp_data[1:0]])
    else $error("new channel context not clean");
  chk_close_extra: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    (exec && act_close) |=> rsp_sw1 == SW1_OK && rsp_sw2 == SW2_OK && !open_reg[$past(close_chan)])
    else $error("close of extra channel failed");
  chk_sf3_content: assert property (
    @(posedge sys_clk) disable iff (!arst_n)
    (CHAN_EN && atr_sf3_present) |-> atr_sf3[SF3_CARD_BIT]
    && atr_sf3[2:0] >= 3'h1 && atr_sf3[2:0] <= 3'h3)
    else $error("capability byte wrong");

endmodule

// ### testbench/clm_term_model.sv
// terminal model that issues one command and collects its answer
`timescale 1ns/100ps
module clm_term_model (
  // clock
  input  wire logic        sys_clk,
  // command side
  output logic             cmd_valid,
  input  wire logic        cmd_ready,
  output logic [1:0]       cmd_chan,
  output logic [7:0]       cmd_ins,
  output logic [7:0]       cmd_p1,
  output logic [7:0]       cmd_p2,
  output logic [15:0]      cmd_fid,
  // response side
  input  wire logic        rsp_valid,
  input  wire logic [7:0]  rsp_sw1,
  input  wire logic [7:0]  rsp_sw2,
  input  wire logic [15:0] rsp_data
);
  // quiet bus from time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_chan  = 2'h0;
    cmd_ins   = 8'h00;
    cmd_p1    = 8'h00;
    cmd_p2    = 8'h00;
    cmd_fid   = 16'h0000;
  end

  // strictly one command in flight; the next waits for this answer
  task automatic send(input logic [1:0] ch, input logic [7:0] ins, input logic [7:0] a,
                      input logic [7:0] b, input logic [15:0] fid,
                      output logic [15:0] sw, output logic [15:0] data,
                      output int lat);
    int n;
    n = 0;
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_chan  = ch;
    cmd_ins   = ins;
    cmd_p1    = a;
    cmd_p2    = b;
    cmd_fid   = fid;
    // ready is settled at the falling edge, so the next rising edge takes it
    while (cmd_ready !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    // released lines must not keep showing the old command
    cmd_chan  = ~cmd_chan;
    cmd_ins   = ~cmd_ins;
    cmd_p1    = ~cmd_p1;
    cmd_p2    = ~cmd_p2;
    cmd_fid   = ~cmd_fid;
    lat = 1;
    while (rsp_valid !== 1'b1 && lat < 20) begin
      @(negedge sys_clk);
      lat++;
    end
    sw   = {rsp_sw1, rsp_sw2};
    data = rsp_data;
  endtask
endmodule

// ### testbench/testbench.sv
// self-checking bench for the logical channel manager
`timescale 1ns/100ps
module testbench;
  import clm_pkg::*;

  // status words the card answers with
  localparam logic [15:0] OK     = {SW1_OK, SW2_OK};
  localparam logic [15:0] E_CH   = {SW1_CLA, SW2_CH_BAD};
  localparam logic [15:0] E_P    = {SW1_WRONG_P, SW2_BAD_P12};
  localparam logic [15:0] E_FULL = {SW1_WRONG_P, SW2_FULL};
  localparam logic [15:0] E_LEAF = {SW1_NOT_ALW, SW2_NO_LEAF};
  localparam logic [15:0] E_NF   = {SW1_WRONG_P, SW2_NO_FILE};
  localparam logic [15:0] E_INS  = {SW1_BAD_INS, SW2_BAD_INS};

  // clock, reset and the two cards' buses
  logic        sys_clk;
  logic        arst_n;
  logic [1:0]  valid, ready, rsp_v, sf3_p;
  logic [1:0]  chan [2];
  logic [7:0]  ins [2], p1 [2], p2 [2], sw1 [2], sw2 [2], sf3 [2];
  logic [15:0] fid [2], data [2];
  logic [15:0] got;
  int          fail_count = 0;
  int          num_checks = 0;
  int          cycles = 0;

  // card 0 supports channels, card 1 does not
  for (genvar i = 0; i < 2; i++) begin : card
    clm_channel_mgr #(.CHAN_EN(i == 0)) dut (
      .sys_clk(sys_clk), .arst_n(arst_n), .cmd_valid(valid[i]), .cmd_ready(ready[i]),
      .cmd_chan(chan[i]), .cmd_ins(ins[i]), .cmd_p1(p1[i]), .cmd_p2(p2[i]),
      .cmd_fid(fid[i]), .rsp_valid(rsp_v[i]), .rsp_sw1(sw1[i]), .rsp_sw2(sw2[i]),
      .rsp_data(data[i]), .atr_sf3_present(sf3_p[i]), .atr_sf3(sf3[i]));
    clm_term_model term (
      .sys_clk(sys_clk), .cmd_valid(valid[i]), .cmd_ready(ready[i]), .cmd_chan(chan[i]),
      .cmd_ins(ins[i]), .cmd_p1(p1[i]), .cmd_p2(p2[i]), .cmd_fid(fid[i]),
      .rsp_valid(rsp_v[i]), .rsp_sw1(sw1[i]), .rsp_sw2(sw2[i]), .rsp_data(data[i]));
  end

  // 20 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // cut a hang short; the whole run needs about 140 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      report_and_stop();
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic apply_reset();
    arst_n = 1'b0;
    repeat (5) @(negedge sys_clk);
    arst_n = 1'b1;
    @(negedge sys_clk);
  endtask

  // one command on card c, status word and answer timing judged
  task automatic do_cmd(input int c, input logic [1:0] ch, input logic [7:0] i_b,
                        input logic [7:0] a, input logic [7:0] b, input logic [15:0] f,
                        input logic [15:0] exp_sw);
    logic [15:0] sw;
    int          lat;
    if (c == 0) card[0].term.send(ch, i_b, a, b, f, sw, got, lat);
    else card[1].term.send(ch, i_b, a, b, f, sw, got, lat);
    check("status word", sw, exp_sw);
    check("answer latency", 16'(lat), 16'h0002);
    check("busy until answer", 16'(ready[c]), 16'h0000);
  endtask

  task automatic t_atr();
    check("sf3 present", 16'(sf3_p[0]), 16'h0001);
    check("sf3 card assignment", 16'(sf3[0][SF3_CARD_BIT]), 16'h0001);
    check("sf3 channel total", 16'(sf3[0][2:0]) + 16'h0001, 16'h0004);
    check("sf3 support cleared", 16'(sf3[1][SF3_CARD_BIT]), 16'h0000);
    check("sf3 byte cleared", 16'(sf3[1]), 16'(SF3_NONE));
    $display("test atr done");
  endtask

  task automatic t_basic();
    do_cmd(0, 2'h0, INS_MANAGE, P1_CLOSE, 8'h00, 16'h0000, E_P);
    do_cmd(0, 2'h0, INS_STATUS, 8'h00, 8'h00, 16'h0000, OK);
    check("basic dir", got, FID_ROOT);
    do_cmd(0, 2'h0, INS_RD_BIN, 8'h00, 8'h00, 16'h0000, E_LEAF);
    do_cmd(0, 2'h0, 8'hCA, 8'h00, 8'h00, 16'h0000, E_INS);
    do_cmd(0, 2'h0, INS_MANAGE, 8'h40, 8'h00, 16'h0000, E_P);
    do_cmd(0, 2'h0, INS_MANAGE, P1_CLOSE, 8'h04, 16'h0000, E_P);
    for (int k = 1; k < 4; k++) do_cmd(0, 2'(k), INS_STATUS, 8'h00, 8'h00, 16'h0, E_CH);
    $display("test basic done");
  endtask

  task automatic t_open();
    do_cmd(0, 2'h0, INS_SELECT, P1_SEL_AID, 8'h00, 16'hA0B1, OK);
    do_cmd(0, 2'h0, INS_SELECT, P1_SEL_FID, 8'h00, 16'h7F10, OK);
    do_cmd(0, 2'h0, INS_SELECT, P1_SEL_FID, 8'h00, 16'h6F06, OK);
    for (int k = 1; k < 4; k++) begin
      do_cmd(0, 2'h0, INS_MANAGE, P1_OPEN, 8'h00, 16'h0000, OK);
      check("open number", got, 16'(k));
      do_cmd(0, 2'(k), INS_STATUS, 8'h00, 8'h00, 16'h0000, OK);
      check("new dir", got, FID_ROOT);
    end
    do_cmd(0, 2'h0, INS_MANAGE, P1_OPEN, 8'h00, 16'h0000, E_FULL);
    do_cmd(0, 2'h0, INS_STATUS, 8'h00, 8'h00, 16'h0000, OK);
    check("basic dir kept", got, 16'h7F10);
    do_cmd(0, 2'h1, INS_RD_REC, 8'h01, 8'h04, 16'h0000, E_LEAF);
    do_cmd(0, 2'h2, INS_SELECT, P1_SEL_FID, 8'h00, FID_APP_ALS, E_NF);
    for (int k = 1; k < 4; k++) begin
      do_cmd(0, 2'h0, INS_MANAGE, P1_CLOSE, 8'(k), 16'h0000, OK);
      do_cmd(0, 2'(k), INS_STATUS, 8'h00, 8'h00, 16'h0000, E_CH);
    end
    do_cmd(0, 2'h0, INS_MANAGE, P1_CLOSE, 8'h01, 16'h0000, E_CH);
    $display("test open done");
  endtask

  task automatic t_extra();
    do_cmd(0, 2'h0, INS_MANAGE, P1_OPEN, 8'h00, 16'h0000, OK);
    check("first free", got, 16'h0001);
    do_cmd(0, 2'h1, INS_SELECT, P1_SEL_AID, 8'h00, 16'hA0B1, OK);
    do_cmd(0, 2'h1, INS_SELECT, P1_SEL_FID, 8'h00, 16'h7F10, OK);
    do_cmd(0, 2'h1, INS_MANAGE, P1_OPEN, 8'h00, 16'h0000, OK);
    check("second free", got, 16'h0002);
    do_cmd(0, 2'h2, INS_STATUS, 8'h00, 8'h00, 16'h0000, OK);
    check("inherited dir", got, 16'h7F10);
    do_cmd(0, 2'h2, INS_RD_REC, 8'h01, 8'h04, 16'h0000, E_LEAF);
    do_cmd(0, 2'h2, INS_SELECT, P1_SEL_FID, 8'h00, FID_APP_ALS, OK);
    check("inherited app", got, 16'hA0B1);
    apply_reset();
    do_cmd(0, 2'h1, INS_STATUS, 8'h00, 8'h00, 16'h0000, E_CH);
    do_cmd(0, 2'h2, INS_STATUS, 8'h00, 8'h00, 16'h0000, E_CH);
    $display("test extra done");
  endtask

  task automatic t_nosup();
    do_cmd(1, 2'h0, INS_MANAGE, P1_OPEN, 8'h00, 16'h0000, E_CH);
    for (int k = 1; k < 4; k++) do_cmd(1, 2'(k), INS_STATUS, 8'h00, 8'h00, 16'h0, E_CH);
    $display("test nosup done");
  endtask

  // main sequence
  initial begin
    arst_n = 1'b0;
    apply_reset();
    t_atr();
    t_basic();
    t_open();
    t_extra();
    t_nosup();
    report_and_stop();
  end
endmodule
